// [tb/e1_line_model.sv]
`timescale 1ns/100ps
`default_nettype none
module e1_line_model
  import e1_rx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Next bit to send
  input wire logic line_bit,
  // Line pins
  output logic rx_line_clk,
  output logic rx_line_positive,
  output logic rx_line_negative,
  // Position of the bit on the line
  output logic pos_frame_is_align,
  output logic [4:0] pos_ts_num,
  output bit_idx_t pos_bit_idx,
  output frame_num_t pos_frame_num
);
  logic [2:0] div_q;
  logic [11:0] pos_q;
  logic mark_q;

  // Eight mclk per bit keeps the three-stage filter well inside its range
  assign rx_line_clk = div_q[2];
  assign pos_frame_num = pos_q[11:8];
  assign pos_ts_num = pos_q[7:3];
  assign pos_bit_idx = pos_q[2:0];
  assign pos_frame_is_align = !pos_q[8];

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= 3'h0;
      pos_q <= 12'hfff;
      mark_q <= 1'b0;
      rx_line_positive <= 1'b0;
      rx_line_negative <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 3'h1;
      // Data and position change well clear of the filtered strobe
      if (div_q == 3'h2)
      begin
        pos_q <= pos_q + 12'h001;
        rx_line_positive <= line_bit && !mark_q;
        rx_line_negative <= line_bit && mark_q;
        mark_q <= mark_q ^ line_bit;
      end
    end
  end
endmodule // e1_line_model
`default_nettype wire

// [tb/e1_rx_alarm_status_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "e1_rx_defines.svh"
module e1_rx_alarm_status_asserts
  import e1_rx_pkg::*;
#(
  parameter int unsigned CRC_SEARCH_CYCLES = 20
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Line and position
  input wire logic rx_line_clk,
  input wire logic rx_line_positive,
  input wire logic rx_line_negative,
  input wire logic pos_frame_is_align,
  input wire logic [4:0] pos_ts_num,
  input wire logic [2:0] pos_bit_idx,
  input wire logic [3:0] pos_frame_num,
  // Synchronizer state
  input wire logic frame_sync_ok,
  input wire logic crc_mf_sync_ok,
  input wire logic fas_search_active,
  input wire logic cas_search_active,
  input wire logic crc_search_active,
  input wire logic rx_slip_event,
  // Register port and interrupt
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic int_b
);
  // Shadow copies, so reads can be judged without the bodies
  reg_t mask_q;
  logic [1:0] ctrl_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      mask_q <= `RST_RX_ALARM_MASK_ONE;
    else if (reg_wr && reg_addr == `ADDR_RX_ALARM_MASK_ONE)
      mask_q <= reg_wdata;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_q <= `RST_RX_ALARM_CTRL;
    else if (reg_wr && reg_addr == `ADDR_RX_ALARM_CTRL)
      ctrl_q <= reg_wdata[1:0];
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence crc_idle_s;
    (!ctrl_q[`CTRL_CRC_MF_EN_BIT] || crc_mf_sync_ok) [*2];
  endsequence
  sequence sync_rd_s;
    reg_rd && reg_addr == `ADDR_SYNC_STATUS;
  endsequence

  crc_held_zero_a: assert property (crc_idle_s ##0 sync_rd_s |=> reg_rdata[7:3] == 5'h00)
    else $error("sync counter not zero while idle");
  mask_off_a: assert property ((mask_q == 8'h00) [*3] |-> int_b)
    else $error("interrupt with all sources masked");
  los_int_a: assert property ($changed(frame_sync_ok) && mask_q[0] |-> ##[1:6] (!int_b || reg_rd))
    else $error("no interrupt on sync change");
  slip_int_a: assert property (rx_slip_event && mask_q[4] |-> ##[1:6] (!int_b || reg_rd))
    else $error("no interrupt on slip");
  int_hold_a: assert property (!int_b && !reg_rd && !reg_wr && !$past(reg_rd) && !$past(reg_wr)
    |=> !int_b)
    else $error("interrupt released without a read");
  mask_read_a: assert property (reg_rd && !reg_wr && reg_addr == `ADDR_RX_ALARM_MASK_ONE
    |=> reg_rdata == mask_q)
    else $error("mask readback wrong");
  ctrl_read_a: assert property (reg_rd && !reg_wr && reg_addr == `ADDR_RX_ALARM_CTRL
    |=> reg_rdata == {6'h00, ctrl_q})
    else $error("control readback wrong");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule // e1_rx_alarm_status_asserts

bind e1_rx_alarm_status e1_rx_alarm_status_asserts #(.CRC_SEARCH_CYCLES(CRC_SEARCH_CYCLES)) u_asserts (.*);
`default_nettype wire

// [tb/tb_e1_rx_alarm_status.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_e1_rx_alarm_status
  import e1_rx_pkg::*;
;
  localparam int unsigned CRC_CYC = 20;
  localparam int unsigned BIT_CYC = 8;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic line_bit = 1'b1;
  logic frame_sync_ok = 1'b1;
  logic crc_mf_sync_ok = 1'b0;
  logic rx_slip_event = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  reg_t reg_addr = 8'h00;
  reg_t reg_wdata = 8'h00;
  reg_t reg_rdata;
  logic int_b, rx_line_clk, rx_line_positive, rx_line_negative, pos_frame_is_align;
  logic [4:0] pos_ts_num;
  bit_idx_t pos_bit_idx;
  frame_num_t pos_frame_num;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  always #12.5 mclk = ~mclk;

  e1_line_model line_model (
    .mclk(mclk), .rst_b(rst_b), .line_bit(line_bit), .rx_line_clk(rx_line_clk),
    .rx_line_positive(rx_line_positive), .rx_line_negative(rx_line_negative),
    .pos_frame_is_align(pos_frame_is_align), .pos_ts_num(pos_ts_num),
    .pos_bit_idx(pos_bit_idx), .pos_frame_num(pos_frame_num)
  );

  e1_rx_alarm_status #(.CRC_SEARCH_CYCLES(CRC_CYC)) uut (
    .mclk(mclk), .rst_b(rst_b), .rx_line_clk(rx_line_clk),
    .rx_line_positive(rx_line_positive), .rx_line_negative(rx_line_negative),
    .pos_frame_is_align(pos_frame_is_align), .pos_ts_num(pos_ts_num),
    .pos_bit_idx(pos_bit_idx), .pos_frame_num(pos_frame_num),
    .frame_sync_ok(frame_sync_ok), .crc_mf_sync_ok(crc_mf_sync_ok),
    .fas_search_active(1'b1), .cas_search_active(1'b0), .crc_search_active(1'b1),
    .rx_slip_event(rx_slip_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_b(int_b)
  );

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input reg_t got, input reg_t exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input reg_t a, input reg_t d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rchk(input reg_t a, input reg_t m, input reg_t e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    check(reg_rdata & m, e);
  endtask

  task automatic ichk(input logic e);
    check({7'h00, int_b}, {7'h00, e});
  endtask

  task automatic wait_bits(input int n);
    repeat (n * BIT_CYC) @(negedge mclk);
  endtask

  task automatic t_reset;
    rchk(8'h16, 8'hff, 8'h00);
    rchk(8'h20, 8'hff, 8'h00);
    rchk(8'h06, 8'hff, 8'h00);
    rchk(8'h1e, 8'hff, 8'h05);
    wr(8'h1e, 8'hff);
    rchk(8'h1e, 8'hff, 8'h05);
    rchk(8'h55, 8'hff, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_crc;
    wr(8'h20, 8'h01);
    repeat (3 * CRC_CYC + 10) @(negedge mclk);
    rchk(8'h1e, 8'hf8, 8'h08);
    // Fifty search periods, the point where the host would give up
    repeat (47 * CRC_CYC) @(negedge mclk);
    rchk(8'h1e, 8'hf8, 8'hc0);
    repeat (17 * CRC_CYC) @(negedge mclk);
    rchk(8'h1e, 8'hf8, 8'h08);
    crc_mf_sync_ok = 1'b1;
    repeat (4) @(negedge mclk);
    rchk(8'h1e, 8'hf8, 8'h00);
    crc_mf_sync_ok = 1'b0;
    wr(8'h20, 8'h00);
    repeat (5 * CRC_CYC) @(negedge mclk);
    rchk(8'h1e, 8'hf8, 8'h00);
    $display("test crc counter done");
  endtask

  task automatic t_alarms;
    // Two multiframes of ones, one zero in frame 3 slot 16 of the second
    wait_bits(4000);
    @(negedge mclk);
    while (!(pos_frame_num == 4'h3 && pos_ts_num == 5'h0f && pos_bit_idx == 3'h7))
      @(negedge mclk);
    line_bit = 1'b0;
    wait_bits(1);
    line_bit = 1'b1;
    wait_bits(3300);
    ichk(1'b1);
    wr(8'h16, 8'h08);
    repeat (3) @(negedge mclk);
    ichk(1'b0);
    rchk(8'h06, 8'hff, 8'hec);
    repeat (3) @(negedge mclk);
    ichk(1'b1);
    // Live alarms survive the clear, the spent change bit does not
    wr(8'h06, 8'hec);
    rchk(8'h06, 8'hff, 8'hcc);
    $display("test all ones done");
  endtask

  task automatic t_carrier;
    wr(8'h16, 8'h02);
    wr(8'h20, 8'h02);
    line_bit = 1'b0;
    wait_bits(300);
    rchk(8'h06, 8'h02, 8'h00);
    wr(8'h20, 8'h00);
    line_bit = 1'b1;
    wait_bits(1);
    line_bit = 1'b0;
    wait_bits(300);
    ichk(1'b0);
    rchk(8'h06, 8'h02, 8'h02);
    line_bit = 1'b1;
    wait_bits(520);
    ichk(1'b0);
    wr(8'h06, 8'h02);
    rchk(8'h06, 8'h02, 8'h00);
    $display("test carrier loss done");
  endtask

  task automatic t_los_slip;
    wr(8'h16, 8'h11);
    frame_sync_ok = 1'b0;
    repeat (8) @(negedge mclk);
    ichk(1'b0);
    rchk(8'h06, 8'h11, 8'h01);
    rx_slip_event = 1'b1;
    @(negedge mclk);
    rx_slip_event = 1'b0;
    repeat (8) @(negedge mclk);
    ichk(1'b0);
    rchk(8'h06, 8'h11, 8'h11);
    frame_sync_ok = 1'b1;
    repeat (8) @(negedge mclk);
    wr(8'h06, 8'h11);
    rchk(8'h06, 8'h11, 8'h00);
    $display("test sync loss and slip done");
  endtask

  // Longest path is the two-multiframe run, about 65k of the 75k cycles in total; the limit is 95k
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      err_count++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_crc();
    t_alarms();
    t_carrier();
    t_los_slip();
    close_out();
  end
endmodule // tb_e1_rx_alarm_status
`default_nettype wire

// [verilog/e1_rx_alarm_status.sv]
`timescale 1ns/100ps
`default_nettype none
`include "e1_rx_defines.svh"
module e1_rx_alarm_status
  import e1_rx_pkg::*;
#(
  parameter int unsigned CRC_SEARCH_CYCLES = `CRC_SEARCH_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Line pins
  input wire logic rx_line_clk,
  input wire logic rx_line_positive,
  input wire logic rx_line_negative,
  // Frame position of the current bit, from the synchronizer
  input wire logic pos_frame_is_align,
  input wire logic [4:0] pos_ts_num,
  input wire logic [2:0] pos_bit_idx,
  input wire logic [3:0] pos_frame_num,
  // Synchronizer and elastic store state
  input wire logic frame_sync_ok,
  input wire logic crc_mf_sync_ok,
  input wire logic fas_search_active,
  input wire logic cas_search_active,
  input wire logic crc_search_active,
  input wire logic rx_slip_event,
  // Parallel register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic int_b
);
  localparam int unsigned TMR_W = $clog2(CRC_SEARCH_CYCLES + 1);
  sig_mon_if sig_bus ();
  logic [2:0] clk_s_q, pos_s_q, neg_s_q;
  logic clk_f_q, pos_f_q, neg_f_q, bit_stb, bit_val, ra_slot, rd_sr1;
  logic [8:0] ua_cnt_q;
  logic [1:0] ua_zeros_q, ua_zeros_d, ra_ones_q, ra_zeros_q, ctrl_q;
  logic ua_alarm_q, ra_alarm_q, cl_alarm_q, int_b_q;
  logic [11:0] cl_run_q, cl_run_d;
  logic [7:0] cl_win_q;
  logic [5:0] cl_ones_q;
  logic [TMR_W-1:0] crc_tmr_q;
  crc_count_t crc_cnt_q;
  reg_t sr1_q, mask_q, pend_q, src_prev_q, src, pend_set, rdata_q;
  function automatic logic [1:0] sat3(input logic [1:0] v);
    sat3 = (v == 2'h3) ? v : v + 2'h1;
  endfunction

  // Line pins: a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_s_q <= 3'h0;
      pos_s_q <= 3'h0;
      neg_s_q <= 3'h0;
      clk_f_q <= 1'b0;
      pos_f_q <= 1'b0;
      neg_f_q <= 1'b0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[1:0], rx_line_clk};
      pos_s_q <= {pos_s_q[1:0], rx_line_positive};
      neg_s_q <= {neg_s_q[1:0], rx_line_negative};
      if (clk_s_q[1] == clk_s_q[2])
        clk_f_q <= clk_s_q[2];
      if (pos_s_q[1] == pos_s_q[2])
        pos_f_q <= pos_s_q[2];
      if (neg_s_q[1] == neg_s_q[2])
        neg_f_q <= neg_s_q[2];
    end
  end

  assign bit_stb = (clk_s_q[1] == clk_s_q[2]) & clk_s_q[2] & ~clk_f_q;
  // Either rail pulse is a received one
  assign bit_val = pos_f_q | neg_f_q;
  assign sig_bus.bit_stb = bit_stb;
  assign sig_bus.bit_val = bit_val;
  assign sig_bus.ts16 = pos_ts_num == 5'h10;
  assign sig_bus.bit_idx = pos_bit_idx;
  assign sig_bus.frame_num = pos_frame_num;
  sig_ts16_monitor u_sig_mon (
    .mclk(mclk),
    .rst_b(rst_b),
    .mon(sig_bus)
  );
  // Unframed all ones over 512-bit windows
  assign ua_zeros_d = bit_val ? ua_zeros_q : sat3(ua_zeros_q);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ua_cnt_q <= 9'h000;
      ua_zeros_q <= 2'h0;
      ua_alarm_q <= 1'b0;
    end
    else if (bit_stb)
    begin
      ua_cnt_q <= ua_cnt_q + 9'h001;
      if (ua_cnt_q == 9'(`UA_WINDOW_BITS - 1))
      begin
        ua_alarm_q <= ua_zeros_d < 2'(`UA_MIN_ZEROS);
        ua_zeros_q <= 2'h0;
      end
      else
        ua_zeros_q <= ua_zeros_d;
    end
  end

  // Remote alarm, bit 3 of timeslot 0 in non-align frames
  assign ra_slot = bit_stb & ~pos_frame_is_align & (pos_ts_num == 5'h00)
    & (pos_bit_idx == 3'(`RA_BIT_IDX));
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ra_ones_q <= 2'h0;
      ra_zeros_q <= 2'h0;
      ra_alarm_q <= 1'b0;
    end
    else if (ra_slot)
    begin
      ra_ones_q <= bit_val ? sat3(ra_ones_q) : 2'h0;
      ra_zeros_q <= bit_val ? 2'h0 : sat3(ra_zeros_q);
      if (bit_val && sat3(ra_ones_q) == 2'(`RA_RUN))
        ra_alarm_q <= 1'b1;
      else if (!bit_val && sat3(ra_zeros_q) == 2'(`RA_RUN))
        ra_alarm_q <= 1'b0;
    end
  end

  // Carrier loss: zero run sets, ones density over 255 bits clears
  assign cl_run_d = bit_val ? 12'h000
    : (cl_run_q == 12'(`CL_LONG_ZEROS)) ? cl_run_q : cl_run_q + 12'h001;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cl_run_q <= 12'h000;
      cl_win_q <= 8'h00;
      cl_ones_q <= 6'h00;
      cl_alarm_q <= 1'b0;
    end
    else if (bit_stb)
    begin
      cl_run_q <= cl_run_d;
      if (cl_win_q == 8'(`CL_WINDOW_BITS - 1))
      begin
        cl_win_q <= 8'h00;
        cl_ones_q <= 6'h00;
        if (6'(cl_ones_q + 6'(bit_val)) >= 6'(`CL_MIN_ONES))
          cl_alarm_q <= 1'b0;
      end
      else
      begin
        cl_win_q <= cl_win_q + 8'h01;
        if (bit_val && cl_ones_q != 6'(`CL_MIN_ONES))
          cl_ones_q <= cl_ones_q + 6'h01;
      end
      if (cl_run_d == (ctrl_q[`CTRL_CL_LONG_BIT] ? 12'(`CL_LONG_ZEROS)
          : 12'(`CL_SHORT_ZEROS)))
        cl_alarm_q <= 1'b1;
    end
  end

  // CRC multiframe search timer and wrapping six-bit counter
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crc_tmr_q <= '0;
      crc_cnt_q <= 6'h00;
    end
    else if (!ctrl_q[`CTRL_CRC_MF_EN_BIT])
    begin
      crc_tmr_q <= '0;
      crc_cnt_q <= 6'h00;
    end
    else if (crc_mf_sync_ok)
    begin
      crc_tmr_q <= '0;
      crc_cnt_q <= 6'h00;
    end
    else if (crc_tmr_q == TMR_W'(CRC_SEARCH_CYCLES - 1))
    begin
      crc_tmr_q <= '0;
      crc_cnt_q <= crc_cnt_q + 6'h01;
    end
    else
      crc_tmr_q <= crc_tmr_q + TMR_W'(1);
  end

  // Status sources: TS16 alarms and slip in the upper half, line and sync alarms in the lower
  always_comb
  begin
    src = 8'h00;
    src[`SR1_SAO_BIT] = sig_bus.sao_alarm | sig_bus.sig_change;
    src[`SR1_DMA_BIT] = sig_bus.dma_alarm;
    src[`SR1_SAZ_BIT] = sig_bus.saz_alarm | sig_bus.sig_change;
    src[`SR1_SLIP_BIT] = rx_slip_event;
    src[`SR1_UA_BIT] = ua_alarm_q;
    src[`SR1_RA_BIT] = ra_alarm_q;
    src[`SR1_CL_BIT] = cl_alarm_q;
    src[`SR1_LOS_BIT] = ~frame_sync_ok;
  end

  // Upper half (TS16 alarms and slip) interrupts on rise, lower half (line and sync alarms) on either edge
  assign pend_set = {src[7:4] & ~src_prev_q[7:4], src[3:0] ^ src_prev_q[3:0]};
  assign rd_sr1 = reg_rd & (reg_addr == `ADDR_RX_ALARM_STATUS_ONE);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_prev_q <= 8'h00;
      sr1_q <= 8'h00;
      pend_q <= 8'h00;
      int_b_q <= 1'b1;
    end
    else
    begin
      src_prev_q <= src;
      // New set beats a same-cycle clear; a live alarm stays set
      if (reg_wr && reg_addr == `ADDR_RX_ALARM_STATUS_ONE)
        sr1_q <= (sr1_q & ~reg_wdata) | src;
      else
        sr1_q <= sr1_q | src;
      pend_q <= (rd_sr1 ? 8'h00 : pend_q) | pend_set;
      int_b_q <= ~|(pend_q & mask_q);
    end
  end

  // Writable control
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_q <= `RST_RX_ALARM_MASK_ONE;
      ctrl_q <= `RST_RX_ALARM_CTRL;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_RX_ALARM_MASK_ONE)
        mask_q <= reg_wdata;
      if (reg_addr == `ADDR_RX_ALARM_CTRL)
        ctrl_q <= reg_wdata[1:0];
    end
  end

  // Read data is registered, one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_RX_ALARM_STATUS_ONE: rdata_q <= sr1_q;
        `ADDR_RX_ALARM_MASK_ONE: rdata_q <= mask_q;
        `ADDR_SYNC_STATUS: rdata_q <= {crc_cnt_q[5:2], crc_cnt_q[0], fas_search_active,
          cas_search_active, crc_search_active};
        `ADDR_RX_ALARM_CTRL: rdata_q <= {6'h00, ctrl_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  assign int_b = int_b_q;
endmodule // e1_rx_alarm_status
`default_nettype wire

// [verilog/e1_rx_defines.svh]
`ifndef E1_RX_DEFINES_SVH
`define E1_RX_DEFINES_SVH

// Register offsets
`define ADDR_RX_ALARM_STATUS_ONE 8'h06
`define ADDR_RX_ALARM_MASK_ONE 8'h16
`define ADDR_SYNC_STATUS 8'h1e
`define ADDR_RX_ALARM_CTRL 8'h20

// Reset values
`define RST_RX_ALARM_MASK_ONE 8'h00
`define RST_RX_ALARM_CTRL 2'h0

// Control field positions
`define CTRL_CRC_MF_EN_BIT 0
`define CTRL_CL_LONG_BIT 1

// Status bit positions
`define SR1_SAO_BIT 7
`define SR1_DMA_BIT 6
`define SR1_SAZ_BIT 5
`define SR1_SLIP_BIT 4
`define SR1_UA_BIT 3
`define SR1_RA_BIT 2
`define SR1_CL_BIT 1
`define SR1_LOS_BIT 0

// Timing
`define MCLK_PERIOD_NS 25
`define CRC_SEARCH_MS 8
`define CRC_SEARCH_CYCLES ((`CRC_SEARCH_MS * 1000000) / `MCLK_PERIOD_NS)

// Alarm thresholds and bit positions
`define UA_WINDOW_BITS 512
`define UA_MIN_ZEROS 3
`define RA_RUN 3
`define CL_SHORT_ZEROS 255
`define CL_LONG_ZEROS 2048
`define CL_WINDOW_BITS 255
`define CL_MIN_ONES 32
`define SIG_MIN_ZEROS 3
`define DMA_RUN 2
`define DMA_BIT_IDX 5
`define RA_BIT_IDX 2
`define MF_LAST_FRAME 15
`define TS16_LAST_BIT 7

`endif

// [verilog/e1_rx_pkg.sv]
package e1_rx_pkg;
  typedef logic [7:0] reg_t;
  typedef logic [5:0] crc_count_t;
  typedef logic [3:0] frame_num_t;
  typedef logic [2:0] bit_idx_t;
endpackage

// [verilog/sig_mon_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface sig_mon_if;
  import e1_rx_pkg::*;
  logic bit_stb;
  logic bit_val;
  logic ts16;
  bit_idx_t bit_idx;
  frame_num_t frame_num;
  logic sao_alarm;
  logic saz_alarm;
  logic dma_alarm;
  logic sig_change;
  modport mon (
    input bit_stb, bit_val, ts16, bit_idx, frame_num,
    output sao_alarm, saz_alarm, dma_alarm, sig_change
  );
  modport top (
    output bit_stb, bit_val, ts16, bit_idx, frame_num,
    input sao_alarm, saz_alarm, dma_alarm, sig_change
  );
endinterface
`default_nettype wire

// [verilog/sig_ts16_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "e1_rx_defines.svh"
module sig_ts16_monitor
  import e1_rx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Timeslot 16 stream and alarms
  sig_mon_if.mon mon
);
  reg_t byte_q;
  reg_t sig_mem [16];
  logic mem_valid_q;
  logic diff_q;
  logic [1:0] zeros_q;
  logic any_one_q;
  logic [1:0] dma_ones_q;
  logic [1:0] dma_zeros_q;
  logic sao_q;
  logic saz_q;
  logic dma_q;
  logic change_q;
  reg_t byte_d;
  logic [1:0] zeros_d;
  logic any_one_d;
  logic ts16_bit;
  logic byte_done;
  logic mf_end;

  function automatic logic [1:0] sat3(input logic [1:0] v);
    sat3 = (v == 2'h3) ? v : v + 2'h1;
  endfunction

  assign ts16_bit = mon.bit_stb & mon.ts16;
  assign byte_done = ts16_bit & (mon.bit_idx == 3'(`TS16_LAST_BIT));
  assign mf_end = byte_done & (mon.frame_num == 4'(`MF_LAST_FRAME));
  assign byte_d = {byte_q[6:0], mon.bit_val};
  assign zeros_d = mon.bit_val ? zeros_q : sat3(zeros_q);
  assign any_one_d = any_one_q | mon.bit_val;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      byte_q <= 8'h00;
    else if (ts16_bit)
      byte_q <= byte_d;
  end

  // Signaling bytes of the last multiframe, kept for comparison
  always_ff @(posedge mclk)
  begin
    if (byte_done)
      sig_mem[mon.frame_num] <= byte_d;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      diff_q <= 1'b0;
      mem_valid_q <= 1'b0;
      change_q <= 1'b0;
    end
    else
    begin
      change_q <= 1'b0;
      if (byte_done && mem_valid_q && sig_mem[mon.frame_num] != byte_d)
        diff_q <= 1'b1;
      if (mf_end)
      begin
        change_q <= diff_q | (mem_valid_q && sig_mem[mon.frame_num] != byte_d);
        diff_q <= 1'b0;
        mem_valid_q <= 1'b1;
      end
    end
  end

  // Zero and one content over a whole multiframe
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zeros_q <= 2'h0;
      any_one_q <= 1'b0;
      sao_q <= 1'b0;
      saz_q <= 1'b0;
    end
    else if (mf_end)
    begin
      sao_q <= zeros_d < 2'(`SIG_MIN_ZEROS);
      saz_q <= ~any_one_d;
      zeros_q <= 2'h0;
      any_one_q <= 1'b0;
    end
    else if (ts16_bit)
    begin
      zeros_q <= zeros_d;
      any_one_q <= any_one_d;
    end
  end

  // Distant multiframe bit, frame 0 only
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dma_ones_q <= 2'h0;
      dma_zeros_q <= 2'h0;
      dma_q <= 1'b0;
    end
    else if (ts16_bit && mon.frame_num == 4'h0 && mon.bit_idx == 3'(`DMA_BIT_IDX))
    begin
      dma_ones_q <= mon.bit_val ? sat3(dma_ones_q) : 2'h0;
      dma_zeros_q <= mon.bit_val ? 2'h0 : sat3(dma_zeros_q);
      if (mon.bit_val && sat3(dma_ones_q) >= 2'(`DMA_RUN))
        dma_q <= 1'b1;
      else if (!mon.bit_val && sat3(dma_zeros_q) >= 2'(`DMA_RUN))
        dma_q <= 1'b0;
    end
  end

  assign mon.sao_alarm = sao_q;
  assign mon.saz_alarm = saz_q;
  assign mon.dma_alarm = dma_q;
  assign mon.sig_change = change_q;
endmodule // sig_ts16_monitor
`default_nettype wire
